// file: iesw_params.svh
// Purpose: Named constants for the interrupt enable and sleep/wake block.
// Assumes: Included by its bare name from the design file.
// Notes: Offsets are byte addresses on the AXI4-Lite register bus.
`ifndef IESW_PARAMS_SVH
`define IESW_PARAMS_SVH
`define IESW_OFF_MASK 4'h0
`define IESW_OFF_SLEEP 4'h4
`define IESW_OFF_STATUS 4'h8
`define IESW_MASK_RESET 8'h00
`define IESW_MASK_WMASK 8'hBF
`define IESW_BIT_GLOBAL 7
`define IESW_BIT_EXT0 0
`define IESW_BIT_TMR0 1
`define IESW_BIT_EXT1 2
`define IESW_BIT_TMR1 3
`define IESW_BIT_SER 4
`define IESW_BIT_TMR2 5
`define IESW_CLK_PER_MC 12
`define IESW_IDLE_RESET_MC 2
`define IESW_PH_FIVE_TWO 4'd9
`define IESW_PH_TWO_TWO 4'd3
`define IESW_RESP_OKAY 2'h0
`define IESW_RESP_SLVERR 2'h2
`endif

// file: iesw_pkg.sv
// Purpose: Types shared by the interrupt enable and sleep/wake block.
// Assumes: Nothing beyond the constants header.
// Notes: Sleep state is one-hot.
package iesw_pkg;
  typedef enum logic [2:0] {
    IESW_RUN = 3'h1,
    IESW_IDLE = 3'h2,
    IESW_PDOWN = 3'h4
  } iesw_sleep_e;
  typedef logic [5:0] iesw_src_t;
endpackage : iesw_pkg

// file: iesw_core.sv
// Purpose: Interrupt enable, request gating, fixed priority and idle/power-down control.
// Assumes: Sources, phase counter and CPU strobes are synchronous to mclk_in.
// Notes: Registers reached over AXI4-Lite; sleep entry by register write or CPU strobe.
`timescale 1ns/1ns
`include "iesw_params.svh"

// How it works
// - Six sources: two external pins, three timer flags, serial port, each a vector.
// - Per-source enable bit; one lets source request, zero blocks it.
// - Top enable bit is global; zero blocks every request.
// - Enable bits: 5 timer2, 4 serial, 3 timer1, 2 ext1, 1 timer0, 0 ext0.
// - Timer 2 request is overflow flag OR external event flag.
// - Vectoring never clears timer 2 flags; software clears them.
// - Timer 0/1 flags set at phase five-two, sampled next machine cycle.
// - Timer 2 flag set at phase two-two, sampled same machine cycle.
// - Idle halts CPU, peripherals run, registers keep contents.
// - Idle ends on any enabled interrupt or hardware reset.
// - Reset ending idle: up to two cycles run, RAM writes blocked.
// - Power-down stops oscillator; registers hold until exit.
// - Power-down exits only on reset or enabled external request.
// - Reset ending power-down restores registers, leaves RAM alone.
// - Strobes high in idle, low in power-down; port 0 floats externally.
// - Machine cycle is twelve oscillator periods.
module iesw_core #(
  parameter int CLK_PER_MC = `IESW_CLK_PER_MC
) (
  input wire logic mclk_in,
  input wire logic resetn_in,
  input wire logic [3:0] awaddr_in,
  input wire logic awvalid_in,
  output logic awready_out,
  input wire logic [31:0] wdata_in,
  input wire logic [3:0] wstrb_in,
  input wire logic wvalid_in,
  output logic wready_out,
  output logic [1:0] bresp_out,
  output logic bvalid_out,
  input wire logic bready_in,
  input wire logic [3:0] araddr_in,
  input wire logic arvalid_in,
  output logic arready_out,
  output logic [31:0] rdata_out,
  output logic [1:0] rresp_out,
  output logic rvalid_out,
  input wire logic rready_in,
  input wire logic ext_request_zero_in,
  input wire logic ext_request_one_in,
  input wire logic timer0_overflow_flag_in,
  input wire logic timer1_overflow_flag_in,
  input wire logic timer2_overflow_flag_in,
  input wire logic timer2_external_flag_in,
  input wire logic serial_flag_in,
  input wire logic [3:0] phase_in,
  input wire logic idle_enter_in,
  input wire logic pdown_enter_in,
  input wire logic ext_mem_in,
  output logic [5:0] pending_out,
  output logic irq_out,
  output logic [2:0] vector_out,
  output logic cpu_halt_out,
  output logic osc_stop_out,
  output logic ram_write_block_out,
  output logic addr_strobe_out,
  output logic program_store_strobe_out,
  output logic port0_float_out
);
  localparam int RST_CNT = `IESW_IDLE_RESET_MC * CLK_PER_MC;

  // Timer polls need phase five-two inside the cycle; the 4-bit phase and 6-bit guard count cap it
  if (CLK_PER_MC <= `IESW_PH_FIVE_TWO || CLK_PER_MC > 16) begin : g_bad_clk_per_mc
    $error("CLK_PER_MC out of range");
  end

  logic [7:0] interrupt_enable_mask_r;
  iesw_pkg::iesw_sleep_e sleep_r;
  iesw_pkg::iesw_src_t raw_req;
  iesw_pkg::iesw_src_t latched_r;
  iesw_pkg::iesw_src_t gated;
  logic global_irq_allow;
  logic aw_held_r;
  logic w_held_r;
  logic [3:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic wr_go;
  logic [1:0] sleep_req;
  logic ext_wake;
  logic any_wake;
  logic [5:0] rst_cnt_r;

  // Source vector in enable-bit order; timer 2 merges both flags, neither cleared here
  assign raw_req[`IESW_BIT_EXT0] = ext_request_zero_in;
  assign raw_req[`IESW_BIT_TMR0] = timer0_overflow_flag_in;
  assign raw_req[`IESW_BIT_EXT1] = ext_request_one_in;
  assign raw_req[`IESW_BIT_TMR1] = timer1_overflow_flag_in;
  assign raw_req[`IESW_BIT_SER] = serial_flag_in;
  assign raw_req[`IESW_BIT_TMR2] = timer2_overflow_flag_in | timer2_external_flag_in;

  // Poll points: timer 0/1 flags set at five-two are caught a machine cycle later;
  // timer 2 set at two-two is caught at five-two of that same cycle
  generate
    for (genvar i = 0; i < 6; i++) begin : g_poll
      always_ff @(posedge mclk_in) begin
        if (!resetn_in) begin
          latched_r[i] <= 1'b0;
        end else if (i == `IESW_BIT_TMR2) begin
          if (phase_in == `IESW_PH_FIVE_TWO) begin
            latched_r[i] <= raw_req[i];
          end
        end else if (i == `IESW_BIT_TMR0 || i == `IESW_BIT_TMR1) begin
          if (phase_in == `IESW_PH_FIVE_TWO) begin
            latched_r[i] <= raw_req[i];
          end
        end else begin
          latched_r[i] <= raw_req[i];
        end
      end
    end
  endgenerate

  // Global and per-source gating
  assign global_irq_allow = interrupt_enable_mask_r[`IESW_BIT_GLOBAL];
  assign gated = global_irq_allow ? (latched_r & interrupt_enable_mask_r[5:0]) : 6'h00;
  assign pending_out = gated;
  assign irq_out = |gated;

  // Fixed priority: lowest bit order ext0,t0,ext1,t1,ser,t2 matches the wanted ranking
  always_comb begin
    vector_out = 3'h0;
    for (int k = 5; k >= 0; k--) begin
      if (gated[k]) begin
        vector_out = 3'(k);
      end
    end
  end

  // AXI write: capture address and data in either order, answer once both are held
  assign awready_out = !aw_held_r && !bvalid_out;
  assign wready_out = !w_held_r && !bvalid_out;
  assign wr_go = aw_held_r && w_held_r && !bvalid_out;

  always_ff @(posedge mclk_in) begin
    if (!resetn_in) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      aw_addr_r <= 4'h0;
      w_data_r <= 32'h0;
      w_strb_r <= 4'h0;
      bvalid_out <= 1'b0;
      bresp_out <= `IESW_RESP_OKAY;
    end else begin
      if (awvalid_in && awready_out) begin
        aw_held_r <= 1'b1;
        aw_addr_r <= awaddr_in;
      end
      if (wvalid_in && wready_out) begin
        w_held_r <= 1'b1;
        w_data_r <= wdata_in;
        w_strb_r <= wstrb_in;
      end
      if (wr_go) begin
        aw_held_r <= 1'b0;
        w_held_r <= 1'b0;
        bvalid_out <= 1'b1;
        bresp_out <= (aw_addr_r == `IESW_OFF_MASK || aw_addr_r == `IESW_OFF_SLEEP) ? `IESW_RESP_OKAY
                     : `IESW_RESP_SLVERR;
      end else if (bvalid_out && bready_in) begin
        bvalid_out <= 1'b0;
      end
    end
  end

  // Enable mask: bit 6 kept at zero whatever software writes; reset restores it
  always_ff @(posedge mclk_in) begin
    if (!resetn_in) begin
      interrupt_enable_mask_r <= `IESW_MASK_RESET;
    end else if (wr_go && aw_addr_r == `IESW_OFF_MASK && w_strb_r[0]) begin
      interrupt_enable_mask_r <= w_data_r[7:0] & `IESW_MASK_WMASK;
    end
  end

  // Sleep entry: bit 0 idle, bit 1 power-down; power-down wins if both
  assign sleep_req[0] = idle_enter_in | (wr_go && aw_addr_r == `IESW_OFF_SLEEP && w_strb_r[0] && w_data_r[0]);
  assign sleep_req[1] = pdown_enter_in | (wr_go && aw_addr_r == `IESW_OFF_SLEEP && w_strb_r[0] && w_data_r[1]);
  assign ext_wake = |(gated & 6'h05);
  assign any_wake = |gated;

  // Sleep state; enabled requests end idle, only external ones end power-down
  always_ff @(posedge mclk_in) begin
    if (!resetn_in) begin
      sleep_r <= iesw_pkg::IESW_RUN;
    end else begin
      case (sleep_r)
        iesw_pkg::IESW_RUN: begin
          if (sleep_req[1]) begin
            sleep_r <= iesw_pkg::IESW_PDOWN;
          end else if (sleep_req[0]) begin
            sleep_r <= iesw_pkg::IESW_IDLE;
          end
        end
        iesw_pkg::IESW_IDLE: begin
          if (any_wake) begin
            sleep_r <= iesw_pkg::IESW_RUN;
          end
        end
        iesw_pkg::IESW_PDOWN: begin
          if (ext_wake) begin
            sleep_r <= iesw_pkg::IESW_RUN;
          end
        end
        default: begin
          sleep_r <= iesw_pkg::IESW_RUN;
        end
      endcase
    end
  end

  // A reset that catches idle blocks RAM writes for two machine cycles; port pins stay free.
  // The count runs on through a held reset; unknowns at power-up fall to the zero branch
  always_ff @(posedge mclk_in) begin
    if (!resetn_in && sleep_r == iesw_pkg::IESW_IDLE) begin
      rst_cnt_r <= 6'(RST_CNT);
    end else if (rst_cnt_r != 6'h00) begin
      rst_cnt_r <= rst_cnt_r - 6'h01;
    end else begin
      rst_cnt_r <= 6'h00;
    end
  end

  // Guard stays high from the catching edge until the count runs out
  always_ff @(posedge mclk_in) begin
    if ((!resetn_in && sleep_r == iesw_pkg::IESW_IDLE) || rst_cnt_r > 6'h01) begin
      ram_write_block_out <= 1'b1;
    end else begin
      ram_write_block_out <= 1'b0;
    end
  end

  // Sleep pin states: strobes high in idle, low in power-down; port 0 floats with external memory
  always_ff @(posedge mclk_in) begin
    if (!resetn_in) begin
      cpu_halt_out <= 1'b0;
      osc_stop_out <= 1'b0;
      addr_strobe_out <= 1'b1;
      program_store_strobe_out <= 1'b1;
      port0_float_out <= 1'b0;
    end else begin
      cpu_halt_out <= (sleep_r != iesw_pkg::IESW_RUN);
      osc_stop_out <= (sleep_r == iesw_pkg::IESW_PDOWN);
      addr_strobe_out <= (sleep_r != iesw_pkg::IESW_PDOWN);
      program_store_strobe_out <= (sleep_r != iesw_pkg::IESW_PDOWN);
      port0_float_out <= ext_mem_in && (sleep_r != iesw_pkg::IESW_RUN);
    end
  end

  // AXI read: one word per request, held until taken
  assign arready_out = !rvalid_out;
  always_ff @(posedge mclk_in) begin
    if (!resetn_in) begin
      rvalid_out <= 1'b0;
      rdata_out <= 32'h0;
      rresp_out <= `IESW_RESP_OKAY;
    end else if (arvalid_in && arready_out) begin
      rvalid_out <= 1'b1;
      rresp_out <= `IESW_RESP_OKAY;
      case (araddr_in)
        `IESW_OFF_MASK: rdata_out <= {24'h0, interrupt_enable_mask_r};
        `IESW_OFF_SLEEP: rdata_out <= {30'h0, sleep_r == iesw_pkg::IESW_PDOWN, sleep_r == iesw_pkg::IESW_IDLE};
        `IESW_OFF_STATUS: rdata_out <= {20'h0, 1'b0, vector_out, 2'h0, gated};
        default: begin
          rdata_out <= 32'h0;
          rresp_out <= `IESW_RESP_SLVERR;
        end
      endcase
    end else if (rvalid_out && rready_in) begin
      rvalid_out <= 1'b0;
    end
  end

  // Checks
  global_gate_a: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    !global_irq_allow |-> !irq_out) else $error("request passed with global enable low");
  bit_six_a: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    interrupt_enable_mask_r[6] == 1'b0) else $error("reserved enable bit set");
  pdown_wake_a: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    (sleep_r == iesw_pkg::IESW_PDOWN && !ext_wake) |=> sleep_r == iesw_pkg::IESW_PDOWN)
    else $error("power-down left without external request");
  idle_wake_a: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    (sleep_r == iesw_pkg::IESW_IDLE && any_wake) |=> sleep_r == iesw_pkg::IESW_RUN)
    else $error("idle not ended by request");
  strobe_pdown_a: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    sleep_r == iesw_pkg::IESW_PDOWN |=> !addr_strobe_out && !program_store_strobe_out && osc_stop_out)
    else $error("strobes not low in power-down");
  priority_ext0_a: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    gated[0] |-> vector_out == 3'h0) else $error("external 0 not first");
  timer2_or_a: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    (phase_in == `IESW_PH_FIVE_TWO && timer2_external_flag_in) |=> latched_r[5])
    else $error("timer 2 external flag lost");
  ram_guard_on_a: assert property (@(posedge mclk_in)
    (!resetn_in && sleep_r == iesw_pkg::IESW_IDLE) |=> ram_write_block_out)
    else $error("RAM writes not blocked after idle reset");
  ram_guard_off_a: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    rst_cnt_r == 6'h00 |=> !ram_write_block_out) else $error("RAM writes blocked without idle reset");
  timer0_hold_a: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    phase_in != `IESW_PH_FIVE_TWO |=> $stable(latched_r[1])) else $error("timer 0 sampled off phase");
endmodule : iesw_core

// file: iesw_src_model.sv
// Purpose: Partner model of the timer, serial and pin request sources and the phase count.
// Assumes: One machine cycle is CLK_PER_MC clocks of mclk_in.
// Notes: Flags stand until the bench drops its command, as software clears them.
`timescale 1ns/1ns
module iesw_src_model #(
  parameter int CLK_PER_MC = 12
) (
  input wire logic mclk_in,
  input wire logic resetn_in,
  input wire logic [6:0] cmd_in,
  output logic [3:0] phase_out,
  output logic [6:0] flag_out
);
  // Phase index inside the machine cycle
  always_ff @(posedge mclk_in) begin
    if (!resetn_in || phase_out == 4'(CLK_PER_MC - 1)) begin
      phase_out <= 4'h0;
    end else begin
      phase_out <= phase_out + 4'h1;
    end
  end
  // Overflow flags rise only at their own phase; the timer 2 external flag follows its command; nothing here clears them on vectoring
  always_ff @(posedge mclk_in) begin
    if (!resetn_in) begin
      flag_out <= 7'h00;
    end else begin
      flag_out[0] <= cmd_in[0];
      flag_out[2] <= cmd_in[2];
      flag_out[4] <= cmd_in[4];
      flag_out[6] <= cmd_in[6];
      flag_out[1] <= cmd_in[1] & (flag_out[1] | (phase_out == 4'h9));
      flag_out[3] <= cmd_in[3] & (flag_out[3] | (phase_out == 4'h9));
      flag_out[5] <= cmd_in[5] & (flag_out[5] | (phase_out == 4'h3));
    end
  end
endmodule : iesw_src_model

// file: interrupt_enable_and_sleep_wake_tb_top.sv
// Purpose: Self-checking bench for the interrupt gating and sleep/wake block.
// Assumes: 20 MHz clock, synchronous active-low reset, AXI4-Lite register access.
// Notes: Table rows cover gating and priority; bus errors, sleep and reset follow by hand.
`timescale 1ns/1ns
module interrupt_enable_and_sleep_wake_tb_top;
  typedef struct packed {
    logic [7:0] mask;
    logic [6:0] src;
    logic [5:0] pend;
    logic [2:0] vec;
  } iesw_row_s;
  logic mclk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic awvalid_in = 1'b0, wvalid_in = 1'b0, bready_in = 1'b0, arvalid_in = 1'b0, rready_in = 1'b0;
  logic idle_enter_in = 1'b0, pdown_enter_in = 1'b0, ext_mem_in = 1'b1;
  logic [3:0] awaddr_in = 4'h0, araddr_in = 4'h0, wstrb_in = 4'hF, phase_in;
  logic [31:0] wdata_in = 32'h0, rdata_out, rd;
  logic [1:0] bresp_out, rresp_out, rsp;
  logic awready_out, wready_out, bvalid_out, arready_out, rvalid_out, irq_out, cpu_halt_out;
  logic osc_stop_out, ram_write_block_out, addr_strobe_out, program_store_strobe_out, port0_float_out;
  logic [5:0] pending_out;
  logic [2:0] vector_out;
  logic [6:0] cmd = 7'h00, flag;
  int err_total = 0, samples_checked = 0, cycles = 0;
  // Rows: mask written, sources raised, gated requests and first vector expected
  iesw_row_s rows [12] = '{'{8'h3F, 7'h7F, 6'h00, 3'h0}, '{8'hBF, 7'h7F, 6'h3F, 3'h0},
    '{8'h81, 7'h7F, 6'h01, 3'h0}, '{8'h82, 7'h7F, 6'h02, 3'h1}, '{8'h84, 7'h7F, 6'h04, 3'h2},
    '{8'h88, 7'h7F, 6'h08, 3'h3}, '{8'h90, 7'h7F, 6'h10, 3'h4}, '{8'hA0, 7'h20, 6'h20, 3'h5},
    '{8'hA0, 7'h40, 6'h20, 3'h5}, '{8'hBF, 7'h1A, 6'h1A, 3'h1}, '{8'hFF, 7'h00, 6'h00, 3'h0},
    '{8'hBE, 7'h01, 6'h00, 3'h0}};

  always #25 mclk_in = ~mclk_in;

  iesw_src_model u_iesw_src_model (.mclk_in, .resetn_in, .cmd_in(cmd), .phase_out(phase_in), .flag_out(flag));
  iesw_core u_iesw_core (.mclk_in, .resetn_in, .awaddr_in, .awvalid_in, .awready_out, .wdata_in, .wstrb_in,
    .wvalid_in, .wready_out, .bresp_out, .bvalid_out, .bready_in, .araddr_in, .arvalid_in, .arready_out,
    .rdata_out, .rresp_out, .rvalid_out, .rready_in, .ext_request_zero_in(flag[0]),
    .timer0_overflow_flag_in(flag[1]), .ext_request_one_in(flag[2]), .timer1_overflow_flag_in(flag[3]),
    .serial_flag_in(flag[4]), .timer2_overflow_flag_in(flag[5]), .timer2_external_flag_in(flag[6]),
    .phase_in, .idle_enter_in, .pdown_enter_in, .ext_mem_in, .pending_out, .irq_out, .vector_out,
    .cpu_halt_out, .osc_stop_out, .ram_write_block_out, .addr_strobe_out, .program_store_strobe_out,
    .port0_float_out);

  task automatic print_verdict();
    if (err_total == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : print_verdict

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] seen);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  // Write: address and data offered together, each dropped once taken, bready held for the answer
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge mclk_in);
    awaddr_in <= a;
    wdata_in <= d;
    awvalid_in <= 1'b1;
    wvalid_in <= 1'b1;
    bready_in <= 1'b1;
    do begin
      @(posedge mclk_in);
      if (awready_out) awvalid_in <= 1'b0;
      if (wready_out) wvalid_in <= 1'b0;
    end while (bvalid_out !== 1'b1);
    r = bresp_out;
    bready_in <= 1'b0;
  endtask : axi_wr

  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge mclk_in);
    araddr_in <= a;
    arvalid_in <= 1'b1;
    rready_in <= 1'b1;
    do begin
      @(posedge mclk_in);
      if (arready_out) arvalid_in <= 1'b0;
    end while (rvalid_out !== 1'b1);
    d = rdata_out;
    r = rresp_out;
    rready_in <= 1'b0;
  endtask : axi_rd

  // Cycle ceiling well above the whole sequence cuts a hang short
  always @(posedge mclk_in) begin
    cycles++;
    if (cycles == 6000) begin
      err_total++;
      print_verdict();
    end
  end

  initial begin
    repeat (4) @(posedge mclk_in);
    resetn_in <= 1'b1;
    foreach (rows[i]) begin
      axi_wr(4'h0, {24'h0, rows[i].mask}, rsp);
      cmd <= rows[i].src;
      repeat (30) @(posedge mclk_in); // Two machine cycles plus margin for timer sampling
      axi_rd(4'h0, rd, rsp);
      chk("mask", {24'h0, rows[i].mask & 8'hBF}, rd);
      chk("pending", 32'(rows[i].pend), 32'(pending_out));
      chk("irq", 32'(rows[i].pend != 6'h00), 32'(irq_out));
      if (rows[i].pend != 6'h00) chk("vector", 32'(rows[i].vec), 32'(vector_out));
      axi_rd(4'h8, rd, rsp);
      chk("status", 32'(rows[i].pend), 32'(rd[5:0]));
      chk("status_vec", 32'(rows[i].vec), 32'(rd[10:8]));
    end
    // Unmapped place answers with an error and zero data
    axi_rd(4'hC, rd, rsp);
    chk("rd_resp", 32'h2, 32'(rsp));
    chk("rd_data", 32'h0, rd);
    axi_wr(4'hC, 32'hFF, rsp);
    chk("wr_resp", 32'h2, 32'(rsp));
    // Idle via sleep register; a disabled timer request must not wake it
    axi_wr(4'h0, 32'h81, rsp);
    cmd <= 7'h02;
    axi_wr(4'h4, 32'h1, rsp);
    repeat (30) @(posedge mclk_in); // No write right after idle entry
    chk("idle_halt", 32'h1, 32'(cpu_halt_out));
    chk("idle_osc", 32'h0, 32'(osc_stop_out));
    chk("idle_strb", 32'h3, 32'({addr_strobe_out, program_store_strobe_out}));
    chk("idle_p0", 32'h1, 32'(port0_float_out));
    axi_rd(4'h0, rd, rsp);
    chk("idle_mask", 32'h81, rd);
    axi_rd(4'h4, rd, rsp);
    chk("idle_state", 32'h1, rd);
    cmd <= 7'h03;
    for (int i = 0; i < 40 && cpu_halt_out !== 1'b0; i++) @(posedge mclk_in);
    chk("idle_wake", 32'h0, 32'(cpu_halt_out));
    // Power-down by strobe with internal program memory; timer requests stay asleep, external one wakes
    cmd <= 7'h00;
    ext_mem_in <= 1'b0;
    axi_wr(4'h0, 32'h8E, rsp);
    pdown_enter_in <= 1'b1;
    @(posedge mclk_in);
    pdown_enter_in <= 1'b0;
    cmd <= 7'h0A;
    repeat (30) @(posedge mclk_in);
    chk("pd_osc", 32'h1, 32'(osc_stop_out));
    chk("pd_halt", 32'h1, 32'(cpu_halt_out));
    chk("pd_strb", 32'h0, 32'({addr_strobe_out, program_store_strobe_out}));
    chk("pd_p0", 32'h0, 32'(port0_float_out));
    cmd <= 7'h0E;
    for (int i = 0; i < 40 && osc_stop_out !== 1'b0; i++) @(posedge mclk_in);
    chk("pd_wake", 32'h0, 32'(osc_stop_out));
    // Power-down by register with external memory, left through reset; registers return to reset values
    cmd <= 7'h00;
    ext_mem_in <= 1'b1;
    axi_wr(4'h0, 32'h81, rsp);
    axi_wr(4'h4, 32'h2, rsp);
    repeat (4) @(posedge mclk_in);
    chk("pd_reg", 32'h1, 32'(osc_stop_out));
    chk("pd_reg_p0", 32'h1, 32'(port0_float_out));
    axi_rd(4'h4, rd, rsp);
    chk("pd_state", 32'h2, rd);
    resetn_in <= 1'b0;
    repeat (4) @(posedge mclk_in);
    resetn_in <= 1'b1;
    @(posedge mclk_in);
    chk("rst_osc", 32'h0, 32'(osc_stop_out));
    chk("rst_strb", 32'h3, 32'({addr_strobe_out, program_store_strobe_out}));
    chk("rst_ramblk", 32'h0, 32'(ram_write_block_out));
    axi_rd(4'h0, rd, rsp);
    chk("rst_mask", 32'h0, rd);
    // Reset that catches idle guards RAM writes for two machine cycles of twelve clocks
    axi_wr(4'h4, 32'h1, rsp);
    resetn_in <= 1'b0;
    repeat (4) @(posedge mclk_in);
    resetn_in <= 1'b1;
    repeat (20) @(posedge mclk_in);
    chk("ramblk_on", 32'h1, 32'(ram_write_block_out));
    chk("ramblk_halt", 32'h0, 32'(cpu_halt_out));
    repeat (2) @(posedge mclk_in);
    chk("ramblk_off", 32'h0, 32'(ram_write_block_out));
    print_verdict();
  end
endmodule : interrupt_enable_and_sleep_wake_tb_top
